// File: inc/spcf_defs.svh
// constants of the servo command front end
`ifndef SPCF_DEFS_SVH
`define SPCF_DEFS_SVH
`define SPCF_HDR_BYTE 8'h3E
`define SPCF_LEN_BYTE 8'h08
`define SPCF_CMD_READ 8'h30
`define SPCF_CMD_WRAM 8'h31
`define SPCF_NULL_BYTE 8'h00
`define SPCF_ID_SINGLE 11'h140
`define SPCF_ID_ALL 11'h280
`define SPCF_ID_REPLY 11'h240
`define SPCF_CAN_DLC 4'h8
`define SPCF_ADDR_MIN 6'h01
`define SPCF_ADDR_MAX 6'h20
`define SPCF_CRC_INIT 16'hFFFF
`define SPCF_CRC_POLY 16'hA001
`define SPCF_GAIN_RST 8'h00
`define SPCF_CLK_HZ 32'h0131_2D00
`define SPCF_CAN_BPS 32'h000F_4240
`define SPCF_BAUD_115K 32'h0001_C200
`define SPCF_BAUD_500K 32'h0007_A120
`define SPCF_BAUD_1M 32'h000F_4240
`define SPCF_BAUD_1M5 32'h0016_E360
`define SPCF_BAUD_2M5 32'h0026_25A0
`define SPCF_TX_LAST 4'hC
`define SPCF_TX_CRCL 4'hB
`define SPCF_TX_DATA0 4'h3
// longest stall before the last check byte goes out: one character at the slowest rate
`define SPCF_CRCH_WAIT_MAX 11'h7D0
`endif

// File: inc/spcf_pkg.sv
// types and shared functions of the servo command front end
`include "spcf_defs.svh"
package spcf_pkg;
   typedef logic [7:0][7:0] spcf_payload_t;
   typedef enum logic [5:0] {
      RX_HDR = 6'h01, RX_ADDR = 6'h02, RX_LEN = 6'h04,
      RX_DATA = 6'h08, RX_CRCL = 6'h10, RX_CRCH = 6'h20
   } spcf_rx_state_t;
   typedef enum logic [2:0] {
      TX_IDLE = 3'h1, TX_CAN = 3'h2, TX_485 = 3'h4
   } spcf_tx_state_t;

   // one byte of the reflected check, shared by frame receive and send
   function automatic logic [15:0] spcf_crc_byte(input logic [15:0] crc, input logic [7:0] b);
      logic [15:0] c;
      c = crc ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ `SPCF_CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction : spcf_crc_byte
endpackage : spcf_pkg

// File: inc/spcf_byte_if.sv
// byte stream between the frame core and the serial line unit
`timescale 1ns/1ns
`default_nettype none
interface spcf_byte_if;
   logic rx_valid;
   logic rx_err;
   logic [7:0] rx_byte;
   logic tx_valid;
   logic tx_ready;
   logic [7:0] tx_byte;
   modport line (output rx_valid, output rx_err, output rx_byte,
                 input tx_valid, input tx_byte, output tx_ready);
   modport core (input rx_valid, input rx_err, input rx_byte,
                 output tx_valid, output tx_byte, input tx_ready);
endinterface : spcf_byte_if
`default_nettype wire

// File: src/spcf_uart.sv
// serial line unit: 8 data bits, 1 stop bit, no parity, selectable rate
`timescale 1ns/1ns
`default_nettype none
`include "spcf_defs.svh"
module spcf_uart
   import spcf_pkg::*;
(
   input wire logic ref_clk, // core clock
   input wire logic rst_n, // async reset, active low
   input wire logic [2:0] baud_sel, // 0:115200 1:500k 2:1M 3:1.5M 4:2.5M
   input wire logic rs485_rx, // receive pin, asynchronous
   output logic rs485_tx, // transmit pin
   output logic rs485_drv_en_n, // driver enable, low while sending
   spcf_byte_if.line bus // byte stream to the core
);
   // ==========================================================
   // rate selection
   function automatic logic [15:0] baud_div(input logic [2:0] sel);
      logic [31:0] bps;
      case (sel)
         3'h1: bps = `SPCF_BAUD_500K;
         3'h2: bps = `SPCF_BAUD_1M;
         3'h3: bps = `SPCF_BAUD_1M5;
         3'h4: bps = `SPCF_BAUD_2M5;
         default: bps = `SPCF_BAUD_115K;
      endcase
      return 16'((`SPCF_CLK_HZ + bps / 2) / bps);
   endfunction : baud_div

   wire [15:0] div_w = baud_div(baud_sel);
   // ==========================================================
   // receiver
   logic rx_s1_q, rx_s2_q, rx_s3_q, rx_busy_q, rx_valid_q, rx_err_q;
   logic [15:0] rx_cnt_q;
   logic [3:0] rx_bit_q;
   logic [7:0] rx_sh_q, rx_byte_q;
   wire rx_fall = rx_s3_q & ~rx_s2_q;
   wire rx_tick = rx_busy_q & (rx_cnt_q == 16'h0000);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         {rx_s1_q, rx_s2_q, rx_s3_q} <= 3'h7;
      end else begin
         {rx_s1_q, rx_s2_q, rx_s3_q} <= {rs485_rx, rx_s1_q, rx_s2_q};
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_busy_q <= 1'b0;
         rx_cnt_q <= 16'h0000;
         rx_bit_q <= 4'h0;
         rx_sh_q <= 8'h00;
         rx_byte_q <= 8'h00;
         rx_valid_q <= 1'b0;
         rx_err_q <= 1'b0;
      end else begin
         rx_valid_q <= 1'b0;
         rx_err_q <= 1'b0;
         if (!rx_busy_q) begin
            if (rx_fall) begin
               rx_busy_q <= 1'b1;
               rx_cnt_q <= div_w >> 1;
               rx_bit_q <= 4'h0;
            end
         end else if (rx_tick) begin
            rx_cnt_q <= div_w - 16'h0001;
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == 4'h0) begin
               // a glitch that is high again at mid start bit is dropped
               rx_busy_q <= ~rx_s2_q;
            end else if (rx_bit_q <= 4'h8) begin
               rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};
            end else begin
               rx_busy_q <= 1'b0;
               rx_byte_q <= rx_sh_q;
               rx_valid_q <= rx_s2_q;
               rx_err_q <= ~rx_s2_q;
            end
         end else begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
         end
      end
   end

   assign bus.rx_valid = rx_valid_q;
   assign bus.rx_err = rx_err_q;
   assign bus.rx_byte = rx_byte_q;
   // ==========================================================
   // transmitter: start bit, 8 data bits lsb first, stop bit
   logic [9:0] tx_sh_q;
   logic [3:0] tx_left_q;
   logic [15:0] tx_cnt_q;
   wire tx_busy = (tx_left_q != 4'h0);
   assign bus.tx_ready = ~tx_busy;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_sh_q <= 10'h3FF;
         tx_left_q <= 4'h0;
         tx_cnt_q <= 16'h0000;
         rs485_drv_en_n <= 1'b1;
      end else if (!tx_busy) begin
         rs485_drv_en_n <= ~bus.tx_valid;
         if (bus.tx_valid) begin
            tx_sh_q <= {1'b1, bus.tx_byte, 1'b0};
            tx_left_q <= 4'hA;
            tx_cnt_q <= div_w - 16'h0001;
         end
      end else if (tx_cnt_q == 16'h0000) begin
         tx_sh_q <= {1'b1, tx_sh_q[9:1]};
         tx_left_q <= tx_left_q - 4'h1;
         tx_cnt_q <= div_w - 16'h0001;
      end else begin
         tx_cnt_q <= tx_cnt_q - 16'h0001;
      end
   end

   assign rs485_tx = tx_sh_q[0];

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   stop_bit_high_a: assert property (
      (tx_left_q == 4'h1) |-> rs485_tx && !rs485_drv_en_n)
      else $error("stop bit not driven high");
endmodule : spcf_uart
`default_nettype wire

// File: src/spcf_top.sv
// servo command front end: CAN and serial framing, gain read and write
// ==========================================================
// Summary of operation
// - CAN runs at one megabit per second; a bit-rate tick is provided.
// - identifier 0x280 is for all drives and every drive accepts it.
// - replies use CAN identifier 0x240 plus own address.
// - CAN frames are standard data frames with eight data bytes.
// - serial link runs at one of five selectable rates.
// - serial characters: eight data bits, one stop bit, no parity.
// - every serial frame starts with header byte 0x3E.
// - address byte follows header; replies carry own address.
// - length byte follows address, fixed at eight.
// - serial payload equals CAN data, one decoder serves both.
// - serial frame ends with CRC16, low byte first.
// - read reply: 0x30, zero, then the six gains in order.
// - each gain is an unsigned eight-bit code.
// - command 0x31 loads all six gains into volatile storage at once.
// - gain write reply echoes the received payload.
`timescale 1ns/1ns
`default_nettype none
`include "spcf_defs.svh"
module spcf_top
   import spcf_pkg::*;
(
   input wire logic ref_clk, // 20 MHz core clock
   input wire logic rst_n, // async reset, active low
   input wire logic [5:0] drive_addr, // own address, 1 to 32
   input wire logic [2:0] baud_sel, // serial rate select
   input wire logic can_rx_valid, // received CAN frame offered
   output logic can_rx_ready, // frame taken this cycle when valid
   input wire logic [10:0] can_rx_id, // identifier
   input wire logic can_rx_ext, // extended identifier flag
   input wire logic can_rx_rtr, // remote frame flag
   input wire logic [3:0] can_rx_dlc, // data length code
   input wire logic [63:0] can_rx_data, // byte k at bits 8k+7:8k
   output logic can_tx_valid, // reply frame offered
   input wire logic can_tx_ready, // controller takes reply
   output logic [10:0] can_tx_id, // reply identifier
   output logic [3:0] can_tx_dlc, // reply data length code
   output logic [63:0] can_tx_data, // reply data
   output logic can_bit_tick, // one pulse per CAN bit time
   input wire logic rs485_rx, // serial receive pin
   output logic rs485_tx, // serial transmit pin
   output logic rs485_drv_en_n, // serial driver enable, low drives
   output logic [7:0] current_loop_prop_gain, // gain codes in use
   output logic [7:0] current_loop_integral_gain,
   output logic [7:0] speed_loop_prop_gain,
   output logic [7:0] speed_loop_integral_gain,
   output logic [7:0] position_loop_prop_gain,
   output logic [7:0] position_loop_integral_gain
);
   localparam logic [7:0] CAN_DIV = 8'(`SPCF_CLK_HZ / `SPCF_CAN_BPS);
   if (`SPCF_CLK_HZ % `SPCF_CAN_BPS != 0) begin : g_clk_check
      $error("clock is no multiple of CAN rate");
   end

   spcf_byte_if bi ();
   spcf_uart u_uart (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .baud_sel(baud_sel),
      .rs485_rx(rs485_rx),
      .rs485_tx(rs485_tx),
      .rs485_drv_en_n(rs485_drv_en_n),
      .bus(bi.line)
   );
   // ==========================================================
   // CAN bit-rate enable
   logic [7:0] can_div_q;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         can_div_q <= 8'h00;
         can_bit_tick <= 1'b0;
      end else begin
         can_bit_tick <= (can_div_q == CAN_DIV - 8'h01);
         can_div_q <= (can_div_q == CAN_DIV - 8'h01) ? 8'h00 : can_div_q + 8'h01;
      end
   end
   // ==========================================================
   // serial frame receive
   spcf_rx_state_t rxs_q;
   logic [2:0] rx_idx_q;
   logic [15:0] rx_crc_q;
   logic [7:0] rx_crcl_q;
   spcf_payload_t rx_pl_q;
   logic r485_done_q;
   wire own_ok = (drive_addr >= `SPCF_ADDR_MIN) && (drive_addr <= `SPCF_ADDR_MAX);
   wire [7:0] rb = bi.rx_byte;
   wire [15:0] rx_crc_nx = spcf_crc_byte(rx_crc_q, rb);
   wire addr_hit = own_ok && (rb == {2'b00, drive_addr});

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rxs_q <= RX_HDR;
         rx_idx_q <= 3'h0;
         rx_crc_q <= `SPCF_CRC_INIT;
         rx_crcl_q <= 8'h00;
         rx_pl_q <= '0;
         r485_done_q <= 1'b0;
      end else begin
         r485_done_q <= 1'b0;
         if (bi.rx_err) begin
            rxs_q <= RX_HDR;
         end else if (bi.rx_valid) begin
            rx_crc_q <= rx_crc_nx;
            case (rxs_q)
               RX_HDR: begin
                  rx_crc_q <= spcf_crc_byte(`SPCF_CRC_INIT, rb);
                  if (rb == `SPCF_HDR_BYTE) rxs_q <= RX_ADDR;
               end
               RX_ADDR: rxs_q <= addr_hit ? RX_LEN : RX_HDR;
               RX_LEN: begin
                  rx_idx_q <= 3'h0;
                  rxs_q <= (rb == `SPCF_LEN_BYTE) ? RX_DATA : RX_HDR;
               end
               RX_DATA: begin
                  rx_pl_q[rx_idx_q] <= rb;
                  rx_idx_q <= rx_idx_q + 3'h1;
                  if (rx_idx_q == 3'h7) rxs_q <= RX_CRCL;
               end
               RX_CRCL: begin
                  rx_crcl_q <= rb;
                  // check bytes stay out of the running sum
                  rx_crc_q <= rx_crc_q;
                  rxs_q <= RX_CRCH;
               end
               RX_CRCH: begin
                  r485_done_q <= ({rb, rx_crcl_q} == rx_crc_q);
                  rxs_q <= RX_HDR;
               end
               default: rxs_q <= RX_HDR;
            endcase
         end
      end
   end
   // ==========================================================
   // command intake and decode
   spcf_tx_state_t txs_q;
   wire tx_idle = (txs_q == TX_IDLE);
   assign can_rx_ready = tx_idle && !r485_done_q;
   wire can_id_ok = (can_rx_id == `SPCF_ID_ALL) ||
                    (own_ok && can_rx_id == `SPCF_ID_SINGLE + {5'h00, drive_addr});
   wire can_ok = can_rx_valid && !can_rx_ext && !can_rx_rtr
                 && (can_rx_dlc == `SPCF_CAN_DLC) && can_id_ok;
   wire can_go = can_rx_ready && can_ok;
   wire any_go = tx_idle && (r485_done_q || can_go);
   // one payload path serves both buses
   wire spcf_payload_t cmd_pl = r485_done_q ? rx_pl_q : spcf_payload_t'(can_rx_data);
   wire is_read = (cmd_pl[0] == `SPCF_CMD_READ);
   wire is_wram = (cmd_pl[0] == `SPCF_CMD_WRAM);
   wire cmd_go = any_go && (is_read || is_wram);
   wire spcf_payload_t gains_w = {position_loop_integral_gain, position_loop_prop_gain,
                                  speed_loop_integral_gain, speed_loop_prop_gain,
                                  current_loop_integral_gain, current_loop_prop_gain,
                                  `SPCF_NULL_BYTE, `SPCF_CMD_READ};

   spcf_payload_t reply_q;
   logic [5:0] reply_addr_q;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         {position_loop_integral_gain, position_loop_prop_gain} <= {2{`SPCF_GAIN_RST}};
         {speed_loop_integral_gain, speed_loop_prop_gain} <= {2{`SPCF_GAIN_RST}};
         {current_loop_integral_gain, current_loop_prop_gain} <= {2{`SPCF_GAIN_RST}};
         reply_q <= '0;
         reply_addr_q <= 6'h00;
      end else if (cmd_go) begin
         reply_addr_q <= drive_addr;
         reply_q <= is_read ? gains_w : cmd_pl;
         if (is_wram) begin
            // all six codes change in the same cycle
            {position_loop_integral_gain, position_loop_prop_gain,
             speed_loop_integral_gain, speed_loop_prop_gain,
             current_loop_integral_gain, current_loop_prop_gain} <= cmd_pl[7:2];
         end
      end
   end
   // ==========================================================
   // reply send
   logic [3:0] tx_idx_q;
   logic [15:0] tx_crc_q;
   wire tx_hs = bi.tx_valid && bi.tx_ready;
   wire [3:0] dat_idx = tx_idx_q - `SPCF_TX_DATA0;
   assign bi.tx_valid = (txs_q == TX_485);
   assign bi.tx_byte = (tx_idx_q == 4'h0) ? `SPCF_HDR_BYTE :
                       (tx_idx_q == 4'h1) ? {2'b00, reply_addr_q} :
                       (tx_idx_q == 4'h2) ? `SPCF_LEN_BYTE :
                       (tx_idx_q == `SPCF_TX_CRCL) ? tx_crc_q[7:0] :
                       (tx_idx_q == `SPCF_TX_LAST) ? tx_crc_q[15:8] :
                       reply_q[dat_idx[2:0]];
   assign can_tx_valid = (txs_q == TX_CAN);
   assign can_tx_id = `SPCF_ID_REPLY + {5'h00, reply_addr_q};
   assign can_tx_dlc = `SPCF_CAN_DLC;
   assign can_tx_data = reply_q;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         txs_q <= TX_IDLE;
         tx_idx_q <= 4'h0;
         tx_crc_q <= `SPCF_CRC_INIT;
      end else begin
         case (txs_q)
            TX_IDLE: begin
               tx_idx_q <= 4'h0;
               tx_crc_q <= `SPCF_CRC_INIT;
               if (cmd_go) txs_q <= r485_done_q ? TX_485 : TX_CAN;
            end
            TX_CAN: if (can_tx_ready) txs_q <= TX_IDLE;
            TX_485: if (tx_hs) begin
               tx_idx_q <= tx_idx_q + 4'h1;
               if (tx_idx_q < `SPCF_TX_CRCL) tx_crc_q <= spcf_crc_byte(tx_crc_q, bi.tx_byte);
               if (tx_idx_q == `SPCF_TX_LAST) txs_q <= TX_IDLE;
            end
            default: txs_q <= TX_IDLE;
         endcase
      end
   end
   // ==========================================================
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence s_tx_first;
      tx_hs && tx_idx_q == 4'h0;
   endsequence
   sequence s_tx_crc;
      tx_hs && tx_idx_q == `SPCF_TX_CRCL;
   endsequence
   reply_can_id_a: assert property (can_tx_valid |->
      can_tx_id == 11'h240 + {5'h00, reply_addr_q} && can_tx_dlc == 4'h8)
      else $error("CAN reply id or length wrong");
   frame_header_a: assert property (s_tx_first |-> bi.tx_byte == 8'h3E)
      else $error("reply frame does not start with header");
   frame_crc_a: assert property (s_tx_crc |-> bi.tx_byte == tx_crc_q[7:0]
      ##1 (tx_idx_q == `SPCF_TX_LAST && bi.tx_byte == $past(tx_crc_q[15:8])))
      else $error("check bytes out of order");
   // counts the stall before the high check byte; a delay range would be too long here
   logic [10:0] chk_hi_wait_q;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         chk_hi_wait_q <= 11'h000;
      end else begin
         chk_hi_wait_q <= (tx_idx_q == `SPCF_TX_LAST && !tx_hs) ? chk_hi_wait_q + 11'h001 : 11'h000;
      end
   end
   check_high_wait_a: assert property (chk_hi_wait_q < `SPCF_CRCH_WAIT_MAX)
      else $error("high check byte never sent");
   read_reply_a: assert property (cmd_go && is_read |=>
      reply_q[0] == 8'h30 && reply_q[1] == 8'h00 && reply_q[2] == $past(current_loop_prop_gain)
      && reply_q[7] == $past(position_loop_integral_gain))
      else $error("read reply content wrong");
   gain_write_a: assert property (cmd_go && is_wram |=>
      current_loop_prop_gain == $past(cmd_pl[2]) && position_loop_integral_gain == $past(cmd_pl[7]))
      else $error("gains not loaded");
   echo_reply_a: assert property (cmd_go && is_wram |=> reply_q == $past(cmd_pl))
      else $error("write reply is no echo");
   bad_len_a: assert property (bi.rx_valid && !bi.rx_err && rxs_q == RX_LEN
      && rb != 8'h08 |=> rxs_q == RX_HDR)
      else $error("bad length not dropped");
   foreign_addr_a: assert property (bi.rx_valid && !bi.rx_err && rxs_q == RX_ADDR
      && rb != {2'b00, drive_addr} |=> rxs_q == RX_HDR)
      else $error("foreign address accepted");
   can_filter_a: assert property (can_rx_valid && can_rx_ready && !can_ok && !r485_done_q
      |=> txs_q == TX_IDLE)
      else $error("foreign CAN frame answered");
   can_tick_a: assert property (can_bit_tick |=> !can_bit_tick [*8])
      else $error("CAN bit tick too frequent");
endmodule : spcf_top
`default_nettype wire

// File: dv/spcf_host_model.sv
// host controller model on the serial side: sends command frames, collects replies
`timescale 1ns/1ns
`default_nettype none
module spcf_host_model (
   input wire logic ref_clk, // core clock
   input wire logic [2:0] baud_sel, // rate shared with the drive
   input wire logic line_in, // drive transmit pin
   output logic line_out // drive receive pin, idles high
);
   logic [7:0] rx_q[$];
   int div;

   // ==========================================================
   // bit timing
   always_comb begin
      case (baud_sel)
         3'h1: div = 40;
         3'h2: div = 20;
         3'h3: div = 13;
         3'h4: div = 8;
         default: div = 174;
      endcase
   end

   initial line_out = 1'b1;

   function automatic logic [15:0] crc_add(input logic [15:0] c, input logic [7:0] b);
      c = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
      return c;
   endfunction : crc_add

   // ==========================================================
   // frame building, shared by sending and by reply expectations
   function automatic void build(input logic [7:0] h, input logic [7:0] a, input logic [7:0] l,
         input logic [63:0] p, input logic bad, output logic [7:0] b[$]);
      logic [15:0] c;
      b = {h, a, l};
      for (int k = 0; k < 8; k++) b.push_back(p[8*k +: 8]);
      c = 16'hFFFF;
      foreach (b[k]) c = crc_add(c, b[k]);
      c = c ^ {15'h0000, bad}; // a corrupted check is only sent on request
      b.push_back(c[7:0]);
      b.push_back(c[15:8]);
   endfunction : build

   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge ref_clk);
         line_out <= f[i];
         repeat (div - 1) @(posedge ref_clk);
      end
   endtask : send_byte

   task automatic send_frame(input logic [7:0] h, input logic [7:0] a, input logic [7:0] l,
         input logic [63:0] p, input logic bad);
      logic [7:0] b[$];
      build(h, a, l, p, bad, b);
      foreach (b[k]) send_byte(b[k]);
   endtask : send_frame

   // ==========================================================
   // receiver: sample each bit mid-cell
   initial begin : rx_loop
      logic [7:0] b;
      forever begin
         @(negedge line_in);
         repeat (div / 2) @(posedge ref_clk);
         for (int i = 0; i < 8; i++) begin
            repeat (div) @(posedge ref_clk);
            b[i] = line_in;
         end
         repeat (div) @(posedge ref_clk);
         rx_q.push_back(b);
      end
   end
endmodule : spcf_host_model
`default_nettype wire

// File: dv/spcf_top_tb_top.sv
// self-checking testbench of the servo command front end
`timescale 1ns/1ns
`default_nettype none
module spcf_top_tb_top;
   import spcf_pkg::*;
   typedef struct packed {
      logic [5:0] addr;
      logic [10:0] id;
      logic ext;
      logic rtr;
      logic [3:0] dlc;
      logic [63:0] data;
      logic rep;
      logic [63:0] exp;
   } spcf_row_t;
   localparam logic [63:0] W1 = 64'h1955_1955_1955_0031;
   localparam logic [63:0] W2 = 64'h0605_0403_0201_0031;
   localparam logic [63:0] W3 = 64'hF0E1_D2C3_B4A5_0031;
   localparam logic [63:0] R1 = 64'h0000_0000_0000_0030;
   logic ref_clk, rst_n, can_rx_valid, can_rx_ready, can_rx_ext, can_rx_rtr;
   logic can_tx_valid, can_tx_ready, can_bit_tick, rs485_rx, rs485_tx, rs485_drv_en_n;
   logic [5:0] drive_addr;
   logic [2:0] baud_sel;
   logic [10:0] can_rx_id, can_tx_id;
   logic [3:0] can_rx_dlc, can_tx_dlc;
   logic [63:0] can_rx_data, can_tx_data;
   logic [7:0] cp, ci, sp, si, pp, pi;
   logic [47:0] g;
   wire logic [47:0] gains = {pi, pp, si, sp, ci, cp};
   spcf_row_t rows[10];
   int n_errors = 0;
   int total_checks = 0;
   int n;

   spcf_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .drive_addr(drive_addr),
      .baud_sel(baud_sel), .can_rx_valid(can_rx_valid), .can_rx_ready(can_rx_ready),
      .can_rx_id(can_rx_id), .can_rx_ext(can_rx_ext), .can_rx_rtr(can_rx_rtr),
      .can_rx_dlc(can_rx_dlc), .can_rx_data(can_rx_data), .can_tx_valid(can_tx_valid),
      .can_tx_ready(can_tx_ready), .can_tx_id(can_tx_id), .can_tx_dlc(can_tx_dlc),
      .can_tx_data(can_tx_data), .can_bit_tick(can_bit_tick), .rs485_rx(rs485_rx),
      .rs485_tx(rs485_tx), .rs485_drv_en_n(rs485_drv_en_n), .current_loop_prop_gain(cp),
      .current_loop_integral_gain(ci), .speed_loop_prop_gain(sp),
      .speed_loop_integral_gain(si), .position_loop_prop_gain(pp),
      .position_loop_integral_gain(pi));
   spcf_host_model host_u (.ref_clk(ref_clk), .baud_sel(baud_sel), .line_in(rs485_tx),
      .line_out(rs485_rx));

   // ==========================================================
   // shared tasks
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic results;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results

   task automatic can_row(input spcf_row_t r);
      int k;
      @(posedge ref_clk);
      drive_addr <= r.addr;
      can_rx_valid <= 1'b1;
      can_rx_id <= r.id;
      can_rx_ext <= r.ext;
      can_rx_rtr <= r.rtr;
      can_rx_dlc <= r.dlc;
      can_rx_data <= r.data;
      @(negedge ref_clk);
      for (k = 0; k < 50 && can_rx_ready !== 1'b1; k++) @(negedge ref_clk);
      @(posedge ref_clk);
      can_rx_valid <= 1'b0;
      @(negedge ref_clk);
      for (k = 0; k < 8 && can_tx_valid !== 1'b1; k++) @(negedge ref_clk);
      check(can_tx_valid, r.rep);
      if (r.rep) begin
         check({can_tx_id, can_tx_dlc}, {11'h240 + {5'h00, r.addr}, 4'h8});
         check(can_tx_data, r.exp);
         repeat (3) @(negedge ref_clk);
         // reply must stand while the controller stalls, and new frames wait
         check(can_rx_ready, 1'b0);
         check(can_tx_data, r.exp);
         @(posedge ref_clk);
         can_tx_ready <= 1'b1;
         @(posedge ref_clk);
         can_tx_ready <= 1'b0;
         @(negedge ref_clk);
         check(can_tx_valid, 1'b0);
         if (r.data[7:0] == 8'h31) g = r.data[63:16];
      end
      check(gains, g);
   endtask : can_row

   task automatic ser_xfer(input logic [7:0] a, input logic [7:0] l, input logic [63:0] p,
         input logic bad, input logic rep, input logic [63:0] e);
      logic [7:0] q[$];
      int lim;
      lim = rep ? 25000 : 600;
      host_u.rx_q.delete();
      host_u.send_frame(8'h3E, a, l, p, bad);
      host_u.build(8'h3E, 8'h01, 8'h08, e, 1'b0, q);
      for (int k = 0; k < lim && host_u.rx_q.size() < 13; k++) @(posedge ref_clk);
      check(64'(host_u.rx_q.size()), rep ? 64'h000D : 64'h0000);
      if (rep && host_u.rx_q.size() == 13) begin
         foreach (q[k]) check(host_u.rx_q[k], q[k]);
      end
      if (rep && p[7:0] == 8'h31) g = p[63:16];
      check(gains, g);
   endtask : ser_xfer

   // ==========================================================
   // clock, watchdog and main sequence
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   initial begin
      repeat (90000) @(posedge ref_clk);
      n_errors++;
      results();
   end

   initial begin
      rst_n = 1'b0;
      drive_addr = 6'h01;
      baud_sel = 3'h4;
      can_rx_valid = 1'b0;
      can_rx_id = 11'h000;
      can_rx_ext = 1'b0;
      can_rx_rtr = 1'b0;
      can_rx_dlc = 4'h0;
      can_rx_data = 64'h0;
      can_tx_ready = 1'b0;
      g = 48'h0;
      rows = '{
         '{6'h01, 11'h141, 1'b0, 1'b0, 4'h8, W1, 1'b1, W1},
         '{6'h01, 11'h141, 1'b0, 1'b0, 4'h8, R1, 1'b1, 64'h1955_1955_1955_0030},
         '{6'h01, 11'h280, 1'b0, 1'b0, 4'h8, W2, 1'b1, W2},
         '{6'h20, 11'h160, 1'b0, 1'b0, 4'h8, R1, 1'b1, 64'h0605_0403_0201_0030},
         '{6'h01, 11'h142, 1'b0, 1'b0, 4'h8, W1, 1'b0, 64'h0},
         '{6'h01, 11'h141, 1'b1, 1'b0, 4'h8, W1, 1'b0, 64'h0},
         '{6'h01, 11'h141, 1'b0, 1'b1, 4'h8, W1, 1'b0, 64'h0},
         '{6'h01, 11'h141, 1'b0, 1'b0, 4'h7, W1, 1'b0, 64'h0},
         '{6'h01, 11'h141, 1'b0, 1'b0, 4'h8, 64'h1955_1955_1955_0032, 1'b0, 64'h0},
         '{6'h20, 11'h141, 1'b0, 1'b0, 4'h8, W1, 1'b0, 64'h0}
      };
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(negedge ref_clk);
      check({can_rx_ready, can_tx_valid, rs485_tx, rs485_drv_en_n, can_tx_dlc}, 8'hB8);
      check(gains, 48'h0);
      n = 0;
      repeat (200) begin
         @(negedge ref_clk);
         if (can_bit_tick === 1'b1) n++;
      end
      check(n, 10);
      foreach (rows[i]) can_row(rows[i]);
      @(posedge ref_clk);
      drive_addr <= 6'h01;
      for (int s = 0; s < 5; s++) begin
         @(posedge ref_clk);
         baud_sel <= s[2:0];
         repeat (4) @(posedge ref_clk);
         ser_xfer(8'h01, 8'h08, R1, 1'b0, 1'b1, {g, 16'h0030});
      end
      ser_xfer(8'h01, 8'h08, W1, 1'b1, 1'b0, 64'h0);
      ser_xfer(8'h01, 8'h07, W1, 1'b0, 1'b0, 64'h0);
      ser_xfer(8'h02, 8'h08, W1, 1'b0, 1'b0, 64'h0);
      host_u.send_byte(8'h55);
      ser_xfer(8'h01, 8'h08, W3, 1'b0, 1'b1, W3);
      // a second reset in mid-run must drop the volatile gains
      @(posedge ref_clk);
      rst_n <= 1'b0;
      @(posedge ref_clk);
      rst_n <= 1'b1;
      @(negedge ref_clk);
      check(gains, 48'h0);
      results();
   end
endmodule : spcf_top_tb_top
`default_nettype wire
